/* File: hw/clk_standby_pkg.sv */
// constants and carrier types for clock division and module standby
package clk_standby_pkg;
  localparam int          DIV_SEL_W        = 3;
  localparam int          PSC_W            = 13;          // taps phi/2 .. phi/8192
  localparam int          NUM_MODULES      = 8;
  localparam int          CAL_TIMER_IDX    = 0;           // calendar timer slot
  localparam logic [2:0]  DIV_SEL_RESET    = 3'h0;        // divide by 1
  localparam logic [2:0]  DIV_SEL_MAX      = 3'h5;        // divide by 32
  localparam logic        PSC_STOP_RESET   = 1'h1;
  localparam logic [7:0]  STANDBY_RESET    = 8'hfe;       // all but calendar timer
  localparam logic [7:0]  TRIM_RESET       = 8'h80;
  localparam int          TRIM_W           = 8;
  localparam int          CAPT_W           = 16;

  typedef struct packed {
    logic [2:0] bus_master_divisor_select;
    logic       prescaler_stop_bit;
  } clk_cfg_type;

  typedef struct packed {
    logic             valid;
    logic [CAPT_W-1:0] count;
  } capture_type;
endpackage

/* File: hw/clock_division_and_module_standby.sv */
// bus-master divider, peripheral prescaler, module standby and oscillator trim
`timescale 1ns/10ps
`default_nettype none
module clock_division_and_module_standby #(
  parameter int NUM_MODULES = clk_standby_pkg::NUM_MODULES
) (
  input  wire logic                     core_clk_i,          // system clock
  input  wire logic                     rstn_i,              // async reset, low
  input  wire clk_standby_pkg::clk_cfg_type cfg_i,           // divisor and stop bit
  input  wire logic                     cfg_we_i,            // write cfg pulse
  input  wire logic [NUM_MODULES-1:0]   module_standby_control_i, // standby bits
  input  wire logic                     standby_we_i,        // write standby pulse
  input  wire logic [7:0]               trim_i,              // trim write value
  input  wire logic                     trim_we_i,           // write trim pulse
  input  wire logic [NUM_MODULES-1:0]   periph_acc_i,        // register access req
  input  wire logic                     capture_in_i,        // reference pulse
  output logic                          bus_clk_en_o,        // bus-master enable
  output logic                          periph_clk_en_o,     // undivided periph en
  output logic [12:0]                   psc_tap_en_o,        // prescaler tap enables
  output logic [NUM_MODULES-1:0]        module_clk_en_o,     // per-module enable
  output logic [NUM_MODULES-1:0]        periph_acc_ok_o,     // access gated
  output logic [NUM_MODULES-1:0]        standby_o,           // standby state
  output logic                          prescaler_stop_bit_o,// stop bit state
  output logic [2:0]                    divisor_o,           // active divisor
  output logic [7:0]                    oscillator_trim_value_o, // trim value
  output var clk_standby_pkg::capture_type capture_o         // capture result
);
  logic [2:0]             div_sel_reg, div_sel_next;
  logic [2:0]             div_pend_reg, div_pend_next;
  logic [4:0]             div_cnt_reg, div_cnt_next;
  logic                   bus_en_reg, bus_en_next;
  logic                   stop_reg, stop_next;
  logic [12:0]            psc_reg, psc_next;
  logic [12:0]            tap_reg, tap_next;
  logic [NUM_MODULES-1:0] stby_reg, stby_next;
  logic [NUM_MODULES-1:0] mclk_reg, mclk_next;
  logic [NUM_MODULES-1:0] acc_reg, acc_next;
  logic [7:0]             trim_reg, trim_next;
  logic [15:0]            cnt_reg, cnt_next;
  logic                   cap_d_reg, cap_d_next;
  logic                   periph_en_reg, periph_en_next;
  clk_standby_pkg::capture_type cap_reg, cap_next;

  // divide-by ratio minus one for a divisor code
  function automatic logic [4:0] div_limit(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > clk_standby_pkg::DIV_SEL_MAX) ? clk_standby_pkg::DIV_SEL_MAX : sel;
    div_limit = 5'((6'h01 << s) - 6'h01);
  endfunction

  // tap i fires when the low i+1 prescaler bits are all ones
  function automatic logic [12:0] carry_taps(input logic [12:0] cnt);
    logic [12:0] t;
    t[0] = cnt[0];
    for (int i = 1; i < clk_standby_pkg::PSC_W; i++) begin
      t[i] = t[i-1] & cnt[i];
    end
    carry_taps = t;
  endfunction

  always_comb begin
    div_pend_next = div_pend_reg;
    if (cfg_we_i) begin
      div_pend_next = cfg_i.bus_master_divisor_select;
    end
    div_sel_next = div_sel_reg;
    div_cnt_next = div_cnt_reg + 5'h01;
    bus_en_next  = 1'b0;
    if (div_cnt_reg >= div_limit(div_sel_reg)) begin
      div_cnt_next = 5'h00;
      bus_en_next  = 1'b1;
      // new ratio waits for the wrap, so no phase is cut short
      div_sel_next = div_pend_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_sel_reg  <= clk_standby_pkg::DIV_SEL_RESET;
      div_pend_reg <= clk_standby_pkg::DIV_SEL_RESET;
      div_cnt_reg  <= 5'h00;
      bus_en_reg   <= 1'b0;
    end else begin
      div_sel_reg  <= div_sel_next;
      div_pend_reg <= div_pend_next;
      div_cnt_reg  <= div_cnt_next;
      bus_en_reg   <= bus_en_next;
    end
  end

  // prescaler stop bit; a write lands one cycle after its strobe
  always_comb begin
    stop_next = stop_reg;
    if (cfg_we_i) begin
      stop_next = cfg_i.prescaler_stop_bit;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_reg <= clk_standby_pkg::PSC_STOP_RESET;
    end else begin
      stop_reg <= stop_next;
    end
  end

  // prescaler: counter frozen while stopped, taps pulse on carries
  always_comb begin
    psc_next = psc_reg;
    tap_next = 13'h0000;
    if (!stop_reg) begin
      psc_next = psc_reg + 13'h0001;
      tap_next = carry_taps(psc_reg);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      psc_reg <= 13'h0000;
      tap_reg <= 13'h0000;
    end else begin
      psc_reg <= psc_next;
      tap_reg <= tap_next;
    end
  end

  // standby gating; peripheral enable never follows the bus divisor
  always_comb begin
    stby_next = stby_reg;
    if (standby_we_i) begin
      stby_next = module_standby_control_i;
    end
    mclk_next = ~stby_next;
    // gate on the standby state already in force; grant lags a cycle
    acc_next  = periph_acc_i & ~stby_reg;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stby_reg <= NUM_MODULES'(clk_standby_pkg::STANDBY_RESET);
      mclk_reg <= ~NUM_MODULES'(clk_standby_pkg::STANDBY_RESET);
      acc_reg  <= '0;
    end else begin
      stby_reg <= stby_next;
      mclk_reg <= mclk_next;
      acc_reg  <= acc_next;
    end
  end

  // trim value; every reset restores the default, software must reload
  always_comb begin
    trim_next = trim_reg;
    if (trim_we_i) begin
      trim_next = trim_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trim_reg <= clk_standby_pkg::TRIM_RESET;
    end else begin
      trim_reg <= trim_next;
    end
  end

  // capture of the reference edge at oscillator rate
  always_comb begin
    cnt_next   = cnt_reg + 16'h0001;
    cap_d_next = capture_in_i;            // one-cycle sampling granularity
    cap_next   = '{valid: 1'b0, count: cap_reg.count};
    if (capture_in_i && !cap_d_reg) begin
      cap_next = '{valid: 1'b1, count: cnt_reg};
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg   <= 16'h0000;
      cap_d_reg <= 1'b0;
      cap_reg   <= '0;
    end else begin
      cnt_reg   <= cnt_next;
      cap_d_reg <= cap_d_next;
      cap_reg   <= cap_next;
    end
  end

  // peripheral clock stays undivided whatever the bus-master divisor
  always_comb begin
    periph_en_next = 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periph_en_reg <= 1'b1;
    end else begin
      periph_en_reg <= periph_en_next;
    end
  end

  assign bus_clk_en_o            = bus_en_reg;
  assign periph_clk_en_o         = periph_en_reg;
  assign psc_tap_en_o            = tap_reg;
  assign module_clk_en_o         = mclk_reg;
  assign periph_acc_ok_o         = acc_reg;
  assign standby_o               = stby_reg;
  assign prescaler_stop_bit_o    = stop_reg;
  assign divisor_o               = div_sel_reg;
  assign oscillator_trim_value_o = trim_reg;
  assign capture_o               = cap_reg;
endmodule // clock_division_and_module_standby
`default_nettype wire

/* File: tb/clk_standby_asserts.sv */
// assertions on the clock division and module standby block
`timescale 1ns/10ps
`default_nettype none
module clk_standby_asserts #(parameter int NUM_MODULES = 8) (
  input wire logic                         core_clk_i,               // clock
  input wire logic                         rstn_i,                   // reset
  input wire clk_standby_pkg::clk_cfg_type cfg_i,                    // cfg
  input wire logic                         cfg_we_i,                 // cfg strobe
  input wire logic [NUM_MODULES-1:0]       module_standby_control_i, // bits
  input wire logic                         standby_we_i,             // strobe
  input wire logic [NUM_MODULES-1:0]       periph_acc_i,             // access
  input wire logic                         bus_clk_en_o,             // bus en
  input wire logic                         periph_clk_en_o,          // periph en
  input wire logic [12:0]                  psc_tap_en_o,             // taps
  input wire logic [NUM_MODULES-1:0]       module_clk_en_o,          // enables
  input wire logic [NUM_MODULES-1:0]       periph_acc_ok_o,          // access ok
  input wire logic [NUM_MODULES-1:0]       standby_o,                // standby
  input wire logic                         prescaler_stop_bit_o,     // stop bit
  input wire logic [2:0]                   divisor_o                 // divisor
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence tap0_pulse;
    psc_tap_en_o[0] ##1 !psc_tap_en_o[0];
  endsequence
  a_clk_en_match: assert property (module_clk_en_o == ~standby_o)
    else $error("module enable not inverse of standby");
  a_standby_write: assert property (standby_we_i |=> standby_o == $past(module_standby_control_i))
    else $error("standby write not taken");
  a_access_gate: assert property (1 |=> (periph_acc_ok_o & ($past(standby_o) | ~$past(periph_acc_i))) == '0)
    else $error("access granted to module in standby");
  a_periph_free: assert property (periph_clk_en_o)
    else $error("peripheral clock gated by divisor");
  a_stop_write: assert property (cfg_we_i |=> prescaler_stop_bit_o == $past(cfg_i.prescaler_stop_bit))
    else $error("stop bit write not taken");
  a_taps_idle: assert property (prescaler_stop_bit_o && $past(prescaler_stop_bit_o) |-> psc_tap_en_o == 13'h0)
    else $error("prescaler taps run while stopped");
  a_tap_period: assert property (tap0_pulse |-> ##1 (psc_tap_en_o[0] || prescaler_stop_bit_o))
    else $error("first tap not every second cycle");
  a_reset_state: assert property ($rose(rstn_i) |-> prescaler_stop_bit_o && standby_o == clk_standby_pkg::STANDBY_RESET)
    else $error("wrong state after reset");
  a_div_boundary: assert property (!$stable(divisor_o) |-> bus_clk_en_o || $past(bus_clk_en_o))
    else $error("divisor changed off a boundary");
endmodule // clk_standby_asserts
bind clock_division_and_module_standby clk_standby_asserts #(.NUM_MODULES(NUM_MODULES)) i_chk (
  .core_clk_i, .rstn_i, .cfg_i, .cfg_we_i, .module_standby_control_i, .standby_we_i,
  .periph_acc_i, .bus_clk_en_o, .periph_clk_en_o, .psc_tap_en_o, .module_clk_en_o,
  .periph_acc_ok_o, .standby_o, .prescaler_stop_bit_o, .divisor_o);
`default_nettype wire

/* File: tb/ref_pulse_model.sv */
// reference pulse source feeding the trim capture input
`timescale 1ns/10ps
`default_nettype none
module ref_pulse_model #(parameter int PERIOD = 40) (
  input  wire logic clk_i,   // system clock
  input  wire logic rstn_i,  // reset
  output var logic  pulse_o  // reference pulse
);
  int cnt = 0;
  // changed off the sampling edge so capture never races
  always @(negedge clk_i) begin
    cnt = (!rstn_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
    pulse_o = (cnt < PERIOD / 2);
  end
endmodule // ref_pulse_model
`default_nettype wire

/* File: tb/tb_clock_division_and_module_standby.sv */
// self-checking bench for clock division and module standby
`timescale 1ns/10ps
`default_nettype none
module tb_clock_division_and_module_standby;
  logic core_clk_i, rstn_i, cfg_we_i, standby_we_i, trim_we_i, capture_in_i;
  logic bus_clk_en_o, periph_clk_en_o, prescaler_stop_bit_o;
  logic [7:0] module_standby_control_i, trim_i, periph_acc_i, module_clk_en_o;
  logic [7:0] periph_acc_ok_o, standby_o, oscillator_trim_value_o;
  logic [12:0] psc_tap_en_o;
  logic [2:0] divisor_o;
  logic [15:0] d;
  logic [15:0] caps[$];
  clk_standby_pkg::clk_cfg_type cfg_i;
  clk_standby_pkg::capture_type capture_o;
  int error_cnt = 0, compares = 0, seed = 32'h78cc54d6, sb, nb, nt, n5;
  clock_division_and_module_standby i_clock_division_and_module_standby (.core_clk_i,
    .rstn_i, .cfg_i, .cfg_we_i, .module_standby_control_i, .standby_we_i, .trim_i,
    .trim_we_i, .periph_acc_i, .capture_in_i, .bus_clk_en_o, .periph_clk_en_o,
    .psc_tap_en_o, .module_clk_en_o, .periph_acc_ok_o, .standby_o, .prescaler_stop_bit_o,
    .divisor_o, .oscillator_trim_value_o, .capture_o);
  ref_pulse_model i_ref_pulse_model (.clk_i(core_clk_i), .rstn_i, .pulse_o(capture_in_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) if (capture_o.valid === 1'b1) caps.push_back(capture_o.count);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // strobes one write: bit2 cfg, bit1 standby, bit0 trim
  task automatic wr(input logic [2:0] we);
    {cfg_we_i, standby_we_i, trim_we_i} = we;
    @(negedge core_clk_i);
    {cfg_we_i, standby_we_i, trim_we_i} = 3'h0;
  endtask
  task automatic cnt();
    nb = 0;
    nt = 0;
    n5 = 0;
    repeat (64) begin
      @(negedge core_clk_i);
      nb += bus_clk_en_o;
      nt += psc_tap_en_o[0];
      n5 += psc_tap_en_o[5];
    end
  endtask
  task automatic rst();
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    @(negedge core_clk_i);
  endtask
  initial begin
    {cfg_we_i, standby_we_i, trim_we_i, cfg_i} = 7'h0;
    {module_standby_control_i, trim_i, periph_acc_i} = 24'h0;
    rst();
    chk(standby_o, clk_standby_pkg::STANDBY_RESET);
    chk(module_clk_en_o, 8'(~clk_standby_pkg::STANDBY_RESET));
    chk(16'(prescaler_stop_bit_o), 16'h1);
    chk(oscillator_trim_value_o, clk_standby_pkg::TRIM_RESET);
    repeat (4) begin
      sb = $random(seed);
      module_standby_control_i = sb[7:0];
      periph_acc_i = 8'($random(seed));
      wr(3'h2);
      @(negedge core_clk_i);
      chk(module_clk_en_o, 8'(~sb[7:0]));
      chk(periph_acc_ok_o, periph_acc_i & ~sb[7:0]);
    end
    module_standby_control_i = 8'hfe;
    wr(3'h2);
    for (int s = 0; s < 6; s++) begin
      cfg_i = {3'(s), 1'b0};
      wr(3'h4);
      repeat (80) @(negedge core_clk_i);
      chk(16'(divisor_o), 16'(s));
      cnt();
      chk(16'(nb), 16'(64 >> s));
      chk(16'(nt), 16'h20);
      chk(16'(n5), 16'h1);
      chk(16'(periph_clk_en_o), 16'h1);
    end
    cfg_i = {3'h5, 1'b1};
    wr(3'h4);
    cnt();
    chk(16'(nt), 16'h0);
    chk(16'(n5), 16'h0);
    chk(standby_o, 8'hfe);
    trim_i = 8'($random(seed));
    wr(3'h1);
    chk(oscillator_trim_value_o, trim_i);
    rst();
    chk(oscillator_trim_value_o, clk_standby_pkg::TRIM_RESET);
    chk(16'(prescaler_stop_bit_o), 16'h1);
    chk(standby_o, clk_standby_pkg::STANDBY_RESET);
    caps.delete();
    repeat (130) @(negedge core_clk_i);
    d = (caps.size() > 2) ? caps[2] - caps[1] : 16'h0;
    chk(16'(d >= 16'd39 && d <= 16'd41), 16'h1);
    conclude();
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule // tb_clock_division_and_module_standby
`default_nettype wire
